// ==== logic/psu_fault_cfg_telemetry_regs.sv ====
// fault configuration and telemetry register bank behind a two-wire serial link
`timescale 1ns/1ps
`include "psu_fault_cfg_regs.svh"

module psu_fault_cfg_telemetry_regs #(
    parameter logic [6:0]  DEV_ADDR = 7'h18,
    parameter logic [15:0] REVISION = 16'h0001   // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        link_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [13:0] output_setpoint_field,
    input  wire logic [13:0] low_threshold_field,
    input  wire logic [13:0] high_threshold_field,
    input  wire logic        bus_switch_enable_field,
    input  wire logic        min_load_field,
    input  wire logic        supply_off_field,
    input  wire logic        fast_setpoint_field,
    input  wire logic        voltage_only_field,
    input  wire logic [3:0]  cable_drop_field,
    input  wire logic [7:0]  current_setpoint_field,
    input  wire logic [7:0]  power_knee_field,
    input  wire logic [1:0]  overvoltage_response_field,
    input  wire logic [9:0]  other_fault_fields,
    input  wire logic [6:0]  fault_events,
    output logic [1:0]       voltage_mode_fault_response,
    output logic [1:0]       voltage_mode_fault_timer,
    output logic [6:0]       voltage_mode_fault_delay_ms,
    output logic             thermal_hysteresis_field,
    output logic             interrupt_pulse
);

    // ==================================================================
    // synchronisers
    logic link_rst;
    logic scl_s;
    logic sda_s;
    logic req_s;
    logic ack_s;
    logic req_tog_ff;
    logic ack_tog_ff;

    pin_sync u_rst_sync (.clk(link_clk), .d(srst),       .q(link_rst));
    pin_sync u_scl_sync (.clk(link_clk), .d(scl_in),     .q(scl_s));
    pin_sync u_sda_sync (.clk(link_clk), .d(sda_in),     .q(sda_s));
    pin_sync u_ack_sync (.clk(link_clk), .d(ack_tog_ff), .q(ack_s));
    pin_sync u_req_sync (.clk(ref_clk),  .d(req_tog_ff), .q(req_s));

    // ==================================================================
    // link domain: byte engine
    psu_fault_pkg::link_state_t state_ff, nxt_state;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic [7:0]  shift_ff, nxt_shift;
    logic [7:0]  ptr_ff, nxt_ptr;
    logic        ackflag_ff, nxt_ackflag;
    logic        byte_sel_ff, nxt_byte_sel;
    logic [15:0] word_ff, nxt_word;
    logic        oe_ff, nxt_oe;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic        ack_seen_ff, nxt_ack_seen;
    logic        nxt_req_tog;
    logic        req_wr_ff, nxt_req_wr;
    logic [7:0]  req_addr_ff, nxt_req_addr;
    logic [7:0]  req_data_ff, nxt_req_data;
    logic [15:0] rdata_ff;
    logic [7:0]  rx_byte;
    logic [3:0]  tx_idx;
    logic        scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_rise  = scl_s & ~scl_d_ff;
        scl_fall  = ~scl_s & scl_d_ff;
        start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
        stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
        rx_byte   = {shift_ff[6:0], sda_s};
        tx_idx    = byte_sel_ff ? (4'hF - cnt_ff) : (4'h7 - cnt_ff);
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_shift    = shift_ff;
        nxt_ptr      = ptr_ff;
        nxt_ackflag  = ackflag_ff;
        nxt_byte_sel = byte_sel_ff;
        nxt_word     = word_ff;
        nxt_oe       = oe_ff;
        nxt_ack_seen = ack_seen_ff;
        nxt_req_tog  = req_tog_ff;
        nxt_req_wr   = req_wr_ff;
        nxt_req_addr = req_addr_ff;
        nxt_req_data = req_data_ff;
        // the answer word is held by the register side until the next request
        if (ack_s != ack_seen_ff) begin
            nxt_ack_seen = ack_s;
            nxt_word     = rdata_ff;
        end
        if (start_det) begin
            nxt_state   = psu_fault_pkg::ST_ADDR;
            nxt_cnt     = 4'h0;
            nxt_ackflag = 1'b0;
            nxt_oe      = 1'b0;
        end else if (stop_det) begin
            nxt_state = psu_fault_pkg::ST_IDLE;
            nxt_oe    = 1'b0;
        end else if (scl_rise) begin
            nxt_shift = rx_byte;
            if (cnt_ff == 4'h8) begin
                nxt_cnt     = 4'h0;
                nxt_ackflag = 1'b0;
                if (state_ff == psu_fault_pkg::ST_READ && !ackflag_ff) begin
                    if (sda_s) begin
                        nxt_state = psu_fault_pkg::ST_IDLE;
                    end else if (byte_sel_ff) begin
                        // next word is fetched during the high phase of the ack clock
                        nxt_byte_sel = 1'b0;
                        nxt_ptr      = 8'(ptr_ff + 8'h02);
                        nxt_req_addr = 8'(ptr_ff + 8'h02);
                        nxt_req_wr   = 1'b0;
                        nxt_req_tog  = ~req_tog_ff;
                    end else begin
                        nxt_byte_sel = 1'b1;
                    end
                end
            end else begin
                nxt_cnt = 4'(cnt_ff + 4'h1);
                if (cnt_ff == 4'h7) begin
                    case (state_ff)
                        psu_fault_pkg::ST_ADDR: begin
                            if (rx_byte[7:1] == DEV_ADDR) begin
                                nxt_ackflag = 1'b1;
                                if (rx_byte[0]) begin
                                    nxt_state    = psu_fault_pkg::ST_READ;
                                    nxt_byte_sel = 1'b0;
                                    nxt_req_addr = ptr_ff;
                                    nxt_req_wr   = 1'b0;
                                    nxt_req_tog  = ~req_tog_ff;
                                end else begin
                                    nxt_state = psu_fault_pkg::ST_CMD;
                                end
                            end else begin
                                nxt_state = psu_fault_pkg::ST_IDLE;
                            end
                        end
                        psu_fault_pkg::ST_CMD: begin
                            nxt_ptr     = rx_byte;
                            nxt_ackflag = 1'b1;
                            nxt_state   = psu_fault_pkg::ST_WDATA;
                        end
                        psu_fault_pkg::ST_WDATA: begin
                            nxt_ackflag  = 1'b1;
                            nxt_req_addr = ptr_ff;
                            nxt_req_data = rx_byte;
                            nxt_req_wr   = 1'b1;
                            nxt_req_tog  = ~req_tog_ff;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end else if (scl_fall) begin
            // open drain: only ever pull low, and change only while the clock is low
            if (cnt_ff == 4'h8) begin
                nxt_oe = ackflag_ff;
            end else if (state_ff == psu_fault_pkg::ST_READ) begin
                nxt_oe = ~word_ff[tx_idx];
            end else begin
                nxt_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        scl_d_ff <= scl_s;
        sda_d_ff <= sda_s;
        if (link_rst) begin
            state_ff    <= psu_fault_pkg::ST_IDLE;
            cnt_ff      <= 4'h0;
            shift_ff    <= 8'h00;
            ptr_ff      <= 8'h00;
            ackflag_ff  <= 1'b0;
            byte_sel_ff <= 1'b0;
            word_ff     <= 16'h0000;
            oe_ff       <= 1'b0;
            ack_seen_ff <= 1'b0;
            req_tog_ff  <= 1'b0;
            req_wr_ff   <= 1'b0;
            req_addr_ff <= 8'h00;
            req_data_ff <= 8'h00;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            shift_ff    <= nxt_shift;
            ptr_ff      <= nxt_ptr;
            ackflag_ff  <= nxt_ackflag;
            byte_sel_ff <= nxt_byte_sel;
            word_ff     <= nxt_word;
            oe_ff       <= nxt_oe;
            ack_seen_ff <= nxt_ack_seen;
            req_tog_ff  <= nxt_req_tog;
            req_wr_ff   <= nxt_req_wr;
            req_addr_ff <= nxt_req_addr;
            req_data_ff <= nxt_req_data;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = oe_ff;

    a_stop_release: assert property (@(posedge link_clk) disable iff (link_rst) stop_det |=> !oe_ff)
        else $error("data line still driven after a stop");

    // ==================================================================
    // register domain
    logic        req_seen_ff, nxt_req_seen;
    logic        nxt_ack_tog;
    logic [15:0] nxt_rdata;
    logic [1:0]  resp_ff, nxt_resp;
    logic [1:0]  timer_ff, nxt_timer;
    logic        otp_ff, nxt_otp;
    logic [6:0]  mask_ff, nxt_mask;
    logic        irq_ff, nxt_irq;
    logic [6:0]  delay_ff, nxt_delay;
    logic [15:0] rd_word;
    logic [7:0]  addr7;
    logic        go;
    logic        hit;

    always_comb begin
        go    = req_s != req_seen_ff;
        addr7 = {1'b0, req_addr_ff[`ODD_PARITY_ADDR_BIT-1:0]};
        hit   = |(mask_ff & fault_events);
        case (addr7)
            `REG_REVISION:  rd_word = REVISION;
            `REG_VSET_RB:   rd_word = {~^output_setpoint_field[13:7], output_setpoint_field[13:7],
                                       ~^output_setpoint_field[6:0], output_setpoint_field[6:0]};
            `REG_UV_RB:     rd_word = {~^low_threshold_field[13:7], low_threshold_field[13:7],
                                       ~^low_threshold_field[6:0], low_threshold_field[6:0]};
            `REG_OV_RB:     rd_word = {~^high_threshold_field[13:7], high_threshold_field[13:7],
                                       ~^high_threshold_field[6:0], high_threshold_field[6:0]};
            `REG_CTRL_RB: begin
                rd_word = 16'h0000;
                rd_word[`CTRL_BUS_SWITCH_BIT] = bus_switch_enable_field;
                rd_word[`CTRL_MIN_LOAD_BIT]   = min_load_field;
                rd_word[`CTRL_SUPPLY_OFF_BIT] = supply_off_field;
                rd_word[`CTRL_FAST_SET_BIT]   = fast_setpoint_field;
                rd_word[`CTRL_VOLT_ONLY_BIT]  = voltage_only_field;
                rd_word[`CTRL_THERMAL_BIT]    = otp_ff;
                rd_word[3:0]                  = cable_drop_field;
            end
            `REG_CURPWR_RB: rd_word = {current_setpoint_field, power_knee_field};
            `REG_FAULT_RB:  rd_word = {overvoltage_response_field, other_fault_fields, resp_ff, timer_ff};
            default:        rd_word = 16'h0000;
        endcase
        nxt_req_seen = req_seen_ff;
        nxt_ack_tog  = ack_tog_ff;
        nxt_rdata    = rdata_ff;
        nxt_resp     = resp_ff;
        nxt_timer    = timer_ff;
        nxt_otp      = otp_ff;
        nxt_mask     = mask_ff;
        nxt_irq      = 1'b0;
        // one pulse per arming, then the mask disarms itself
        if (hit) begin
            nxt_irq  = 1'b1;
            nxt_mask = `IRQ_MASK_RESET;
        end
        if (go) begin
            nxt_req_seen = req_s;
            nxt_ack_tog  = ~ack_tog_ff;
            if (req_wr_ff) begin
                // a mask write in the same cycle as a pulse re-arms: software wins
                case (addr7)
                    `OUTPUT_SETPOINT_FIELD_RESP:  nxt_resp  = req_data_ff[1:0];
                    `OUTPUT_SETPOINT_FIELD_TIMER: nxt_timer = req_data_ff[1:0];
                    `REG_IRQ_MASK: nxt_mask  = req_data_ff[6:0];
                    `THERMAL_HYSTERESIS_FIELD:  nxt_otp   = req_data_ff[0];
                    default: begin
                    end
                endcase
            end else begin
                nxt_rdata = rd_word;
            end
        end
        case (timer_ff)
            2'h0:    nxt_delay = `CV_DELAY_CODE0_MS;
            2'h1:    nxt_delay = `CV_DELAY_CODE1_MS;
            2'h2:    nxt_delay = `CV_DELAY_CODE2_MS;
            default: nxt_delay = `CV_DELAY_CODE3_MS;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_seen_ff <= 1'b0;
            ack_tog_ff  <= 1'b0;
            rdata_ff    <= 16'h0000;
            resp_ff     <= `CV_RESP_RESET;
            timer_ff    <= `CV_TIMER_RESET;
            otp_ff      <= `OTP_HYS_RESET;
            mask_ff     <= `IRQ_MASK_RESET;
            irq_ff      <= 1'b0;
            delay_ff    <= `CV_DELAY_CODE0_MS;
        end else begin
            req_seen_ff <= nxt_req_seen;
            ack_tog_ff  <= nxt_ack_tog;
            rdata_ff    <= nxt_rdata;
            resp_ff     <= nxt_resp;
            timer_ff    <= nxt_timer;
            otp_ff      <= nxt_otp;
            mask_ff     <= nxt_mask;
            irq_ff      <= nxt_irq;
            delay_ff    <= nxt_delay;
        end
    end

    assign voltage_mode_fault_response = resp_ff;
    assign voltage_mode_fault_timer    = timer_ff;
    assign voltage_mode_fault_delay_ms = delay_ff;
    assign thermal_hysteresis_field    = otp_ff;
    assign interrupt_pulse             = irq_ff;

    // ==================================================================
    // checks
    sequence s_resp_write;
        go && req_wr_ff && addr7 == `OUTPUT_SETPOINT_FIELD_RESP;
    endsequence

    // a hit with no write racing it must give exactly one pulse and disarm
    sequence s_armed_hit;
        hit && !(go && req_wr_ff);
    endsequence

    sequence s_single_pulse;
        irq_ff && mask_ff == 7'h00 ##1 !irq_ff;
    endsequence

    a_resp_reset: assert property (@(posedge ref_clk) $past(srst) |-> resp_ff == `CV_RESP_NONE)
        else $error("fault response not cleared by reset");
    a_resp_write: assert property (@(posedge ref_clk) disable iff (srst)
        s_resp_write |=> resp_ff == $past(req_data_ff[1:0]))
        else $error("fault response write lost");
    a_timer_delay: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 delay_ff == 7'(7'h08 << $past(timer_ff)))
        else $error("fault delay does not match timer code");
    a_irq_one_shot: assert property (@(posedge ref_clk) disable iff (srst)
        s_armed_hit |=> s_single_pulse)
        else $error("interrupt not a single pulse with mask cleared");
    a_irq_cause: assert property (@(posedge ref_clk) disable iff (srst)
        irq_ff |-> $past(mask_ff & fault_events) != 7'h00)
        else $error("interrupt without armed source");
    a_parity_odd: assert property (@(posedge ref_clk) disable iff (srst)
        go && !req_wr_ff && (addr7 == `REG_VSET_RB || addr7 == `REG_UV_RB || addr7 == `REG_OV_RB)
        |=> (^rdata_ff[15:8]) && (^rdata_ff[7:0]))
        else $error("read-back word lacks odd byte parity");
    a_fault_pack: assert property (@(posedge ref_clk) disable iff (srst)
        go && !req_wr_ff && addr7 == `REG_FAULT_RB
        |=> rdata_ff[15:14] == $past(overvoltage_response_field) && rdata_ff[3:2] == $past(resp_ff))
        else $error("fault response word packed wrongly");

endmodule

// ==== include/psu_fault_cfg_regs.svh ====
// register offsets, field positions, reset values and timer codes of the fault and telemetry bank
`ifndef PSU_FAULT_CFG_REGS_SVH
`define PSU_FAULT_CFG_REGS_SVH

// ==================================================================
// read-back word offsets
`define REG_REVISION         8'h00
`define REG_VSET_RB          8'h02
`define REG_UV_RB            8'h04
`define REG_OV_RB            8'h06
`define REG_CTRL_RB          8'h08
`define REG_CURPWR_RB        8'h0A
`define REG_FAULT_RB         8'h0C

// ==================================================================
// writable byte offsets
`define OUTPUT_SETPOINT_FIELD_RESP          8'h28
`define OUTPUT_SETPOINT_FIELD_TIMER         8'h2A
`define REG_IRQ_MASK         8'h2C
`define THERMAL_HYSTERESIS_FIELD          8'h2E

// the odd-parity alias of every register sets this address bit
`define ODD_PARITY_ADDR_BIT  7

// ==================================================================
// field codes and reset values
`define CV_RESP_NONE         2'h0
`define CV_RESP_AUTO         2'h1
`define CV_RESP_LATCH        2'h2
`define CV_RESP_RESET        2'h0
`define CV_TIMER_RESET       2'h0
`define IRQ_MASK_RESET       7'h00
`define OTP_HYS_RESET        1'h0

// fault timer delays in milliseconds, by code
`define CV_DELAY_CODE0_MS    7'h08
`define CV_DELAY_CODE1_MS    7'h10
`define CV_DELAY_CODE2_MS    7'h20
`define CV_DELAY_CODE3_MS    7'h40

// ==================================================================
// control flag word bit positions
`define CTRL_BUS_SWITCH_BIT  14
`define CTRL_MIN_LOAD_BIT    13
`define CTRL_SUPPLY_OFF_BIT  12
`define CTRL_FAST_SET_BIT    11
`define CTRL_VOLT_ONLY_BIT   10
`define CTRL_THERMAL_BIT     9

`endif

// ==== include/psu_fault_pkg.sv ====
// types shared by the fault and telemetry register bank
package psu_fault_pkg;

    // ==================================================================
    // link byte engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_READ
    } link_state_t;

endpackage

// ==== logic/pin_sync.sv ====
// three-stage synchroniser whose output moves once the last two stages agree
`timescale 1ns/1ps

module pin_sync (
    input  wire logic clk,
    input  wire logic d,
    output logic      q
);

    logic meta_ff;
    logic mid_ff;
    logic late_ff;
    logic q_ff;
    logic nxt_q;

    // ==================================================================
    // agreement filter: a single disagreeing sample never reaches q
    always_comb begin
        nxt_q = (mid_ff == late_ff) ? late_ff : q_ff;
    end

    always_ff @(posedge clk) begin
        meta_ff <= d;
        mid_ff  <= meta_ff;
        late_ff <= mid_ff;
        q_ff    <= nxt_q;
    end

    assign q = q_ff;

endmodule

// ==== verification/link_master_model.sv ====
// behavioural two-wire bus master that sits opposite the register bank
`timescale 1ns/1ps

module link_master_model #(
    parameter logic [6:0] DEV_ADDR = 7'h18
) (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      pull_low
);
    logic [15:0] rd [0:7];
    logic        par_ok [0:7];
    logic        rd_ack;
    logic        idle;

    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
        idle = 1'b1;
        rd_ack = 1'b0;
    end

    // ==================================================================
    // bit level
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // high phase of 650 ns leaves room for the word fetch behind the pins
    task automatic clk_bit(input logic drive, input logic b, output logic s);
        scl = 1'b0;
        tick(20);
        pull_low = drive & ~b;
        tick(20);
        scl = 1'b1;
        tick(60);
        s = sda_line;
        tick(5);
    endtask

    task automatic start_cond;
        logic s;
        if (!idle)
            clk_bit(1'b1, 1'b1, s);
        pull_low = 1'b1;
        tick(40);
        idle = 1'b0;
    endtask

    task automatic stop_cond;
        logic s;
        clk_bit(1'b1, 1'b0, s);
        pull_low = 1'b0;
        tick(40);
        idle = 1'b1;
    endtask

    // ==================================================================
    // byte and transfer level
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i], s);
        clk_bit(1'b0, 1'b0, s);
        ack = ~s;
    endtask

    task automatic byte_in(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, 1'b0, s);
            d[i] = s;
        end
        clk_bit(1'b1, ~more, s);
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                             output logic acked);
        logic a0, a1, a2;
        start_cond();
        byte_out({dev, 1'b0}, a0);
        byte_out(ptr, a1);
        byte_out(d, a2);
        stop_cond();
        acked = a0 & a1 & a2;
    endtask

    task automatic read_words(input logic [7:0] ptr, input int n);
        logic       a0, a1, a2;
        logic [7:0] lo, hi;
        start_cond();
        byte_out({DEV_ADDR, 1'b0}, a0);
        byte_out(ptr, a1);
        start_cond();
        byte_out({DEV_ADDR, 1'b1}, a2);
        for (int i = 0; i < n; i++) begin
            byte_in(1'b1, lo);
            byte_in(i < n - 1, hi);
            rd[i] = {hi, lo};
            par_ok[i] = (^hi) & (^lo);
        end
        stop_cond();
        rd_ack = a0 & a1 & a2;
    endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the fault configuration and telemetry register bank
`timescale 1ns/1ps

module tb;
    localparam logic [15:0] REV_ID = 16'hC35A;   // arbitrary value

    logic        ref_clk, srst, link_clk, scl, m_low, sda_line, sda_out, sda_oe, hys, irq;
    logic        bus_sw, min_ld, psu_off, fast_set, v_only;
    logic [13:0] vset, uv_thr, ov_thr;
    logic [3:0]  cable;
    logic [7:0]  cur_set, knee;
    logic [1:0]  ov_resp, cv_resp, cv_timer;
    logic [9:0]  other_flt;
    logic [6:0]  events, delay_ms;
    int          n_errors, compares, n_pulse;

    // open-drain data line with pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | m_low);

    psu_fault_cfg_telemetry_regs #(.DEV_ADDR(7'h18), .REVISION(REV_ID)) uut (
        .ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .output_setpoint_field(vset),
        .low_threshold_field(uv_thr), .high_threshold_field(ov_thr),
        .bus_switch_enable_field(bus_sw), .min_load_field(min_ld), .supply_off_field(psu_off),
        .fast_setpoint_field(fast_set), .voltage_only_field(v_only), .cable_drop_field(cable),
        .current_setpoint_field(cur_set), .power_knee_field(knee),
        .overvoltage_response_field(ov_resp), .other_fault_fields(other_flt), .fault_events(events),
        .voltage_mode_fault_response(cv_resp), .voltage_mode_fault_timer(cv_timer),
        .voltage_mode_fault_delay_ms(delay_ms), .thermal_hysteresis_field(hys), .interrupt_pulse(irq)
    );

    link_master_model #(.DEV_ADDR(7'h18)) mst (
        .ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .pull_low(m_low)
    );

    // ==================================================================
    // clocks, pulse counter, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    always @(posedge ref_clk) begin
        if (irq === 1'b1)
            n_pulse <= n_pulse + 1;
    end

    // whole run is about 0.75 ms of bus traffic
    initial begin
        #950_000;
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    // ==================================================================
    // helpers
    task automatic close_out;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
        logic ok;
        mst.write_reg(dev, ptr, d, ok);
        chk({15'h0, ok}, {15'h0, dev == 7'h18}, "write ack");
    endtask

    function automatic logic [15:0] par_word(input logic [13:0] x);
        return {~^x[13:7], x[13:7], ~^x[6:0], x[6:0]};
    endfunction

    task automatic fire(input int k, input int exp, input string what);
        int p;
        p = n_pulse;
        events[k] = 1'b1;
        repeat (3) @(negedge ref_clk);
        events[k] = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(16'(n_pulse - p), 16'(exp), what);
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset;
        chk({14'h0, cv_resp}, 16'h0, "response reset");
        chk({14'h0, cv_timer}, 16'h0, "timer reset");
        chk({9'h0, delay_ms}, 16'h8, "delay reset");
        chk({14'h0, hys, sda_oe}, 16'h0, "idle outputs");
        fire(0, 0, "mask reset");
        fire(6, 0, "mask reset");
        $display("test reset done");
    endtask

    task automatic t_resp;
        for (int i = 0; i < 3; i++) begin
            wr(7'h18, i == 1 ? 8'hA8 : 8'h28, 8'hFC | 8'((i + 1) % 3));
            chk({14'h0, cv_resp}, 16'((i + 1) % 3), "response code");
        end
        $display("test response done");
    endtask

    task automatic t_timer;
        for (int c = 1; c < 5; c++) begin
            wr(7'h18, 8'h2A, 8'(c % 4));
            repeat (2) @(negedge ref_clk);
            chk({14'h0, cv_timer}, 16'(c % 4), "timer code");
            chk({9'h0, delay_ms}, 16'(8 << (c % 4)), "timer delay");
        end
        $display("test timer done");
    endtask

    task automatic t_irq;
        wr(7'h18, 8'h2C, 8'h41);
        fire(3, 0, "unarmed source");
        fire(6, 1, "armed source");
        fire(0, 0, "mask cleared");
        wr(7'h18, 8'h2C, 8'h08);
        fire(3, 1, "rearmed source");
        $display("test interrupt done");
    endtask

    task automatic t_access;
        wr(7'h19, 8'h28, 8'h01);
        wr(7'h18, 8'h00, 8'hFF);
        wr(7'h18, 8'h30, 8'h02);
        chk({14'h0, cv_resp}, 16'h0, "response kept");
        mst.read_words(8'h00, 1);
        chk(mst.rd[0], REV_ID, "revision");
        mst.read_words(8'h10, 1);
        chk(mst.rd[0], 16'h0, "unmapped read");
        $display("test access done");
    endtask

    task automatic t_readback;
        wr(7'h18, 8'h2E, 8'h01);
        wr(7'h18, 8'h28, 8'h02);
        wr(7'h18, 8'hAA, 8'h03);
        chk({14'h0, hys, cv_timer[1]}, 16'h3, "hysteresis and alias");
        mst.read_words(8'h82, 6);
        chk({15'h0, mst.rd_ack}, 16'h1, "read ack");
        chk(mst.rd[0], par_word(vset), "setpoint");
        chk(mst.rd[1], par_word(uv_thr), "low threshold");
        chk(mst.rd[2], par_word(ov_thr), "high threshold");
        chk(mst.rd[3], {1'b0, bus_sw, min_ld, psu_off, fast_set, v_only, 1'b1, 5'h00, cable}, "flags");
        chk(mst.rd[4], {cur_set, knee}, "current and knee");
        chk(mst.rd[5], {ov_resp, other_flt, 2'h2, 2'h3}, "fault responses");
        chk({15'h0, mst.par_ok[0] & mst.par_ok[1] & mst.par_ok[2]}, 16'h1, "odd parity");
        mst.read_words(8'h80, 1);
        chk(mst.rd[0], REV_ID, "revision alias");
        $display("test readback done");
    endtask

    // ==================================================================
    // main sequence
    initial begin
        srst = 1'b1;
        events = 7'h00;
        n_errors = 0;
        compares = 0;
        n_pulse = 0;
        vset = 14'h3A81;
        uv_thr = 14'h0C7F;
        ov_thr = 14'h1555;
        {bus_sw, min_ld, psu_off, fast_set, v_only} = 5'h1A;
        cable = 4'hB;
        cur_set = 8'hA7;
        knee = 8'h3C;
        ov_resp = 2'h1;
        other_flt = 10'h2D6;
        // long enough for the three-stage reset sync of the link side: six link clock edges
        repeat (20) @(negedge ref_clk);
        srst = 1'b0;
        repeat (10) @(negedge ref_clk);
        t_reset();
        t_resp();
        t_timer();
        t_irq();
        t_access();
        t_readback();
        close_out();
    end
endmodule
